//--- verilog/dio_port_pkg.sv
/*
 * constants for the digital i/o port block: register byte offsets,
 * reset values, port indices and the single-operation command codes.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
package dio_port_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_DIR_A = 12'h000;
    localparam logic [11:0] OFF_DIR_C = 12'h004;
    localparam logic [11:0] OFF_PU_A = 12'h008;
    localparam logic [11:0] OFF_PU_B = 12'h00C;
    localparam logic [11:0] OFF_PORT_BASE = 12'h010;
    localparam logic [11:0] OFF_OP = 12'h020;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] DIR_A_RESET = 8'h00;
    localparam logic [7:0] DIR_C_RESET = 8'h00;
    localparam logic [7:0] PU_A_RESET = 8'h00;
    localparam logic [7:0] PU_B_RESET = 8'h00;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam int PU_A_PORT0_BIT = 3;
    localparam int PU_A_PORT1_BIT = 6;
    localparam int PU_B_PORT3_BIT = 0;
    localparam int DIR_C_PORT3_BIT = 0;

    // ports in order: index 0..3 (index 2 is the input-only port)
    localparam logic [1:0] PORT_INPUT_ONLY = 2'h2;

    // op register write fields and the read-back result bit
    localparam int OP_CODE_LSB = 0;
    localparam int OP_PORT_LSB = 4;
    localparam int OP_BIT_LSB = 8;
    localparam int OP_CARRY_BIT = 12;
    localparam int OP_DATA_LSB = 16;
    localparam int RESULT_BIT_POS = 4;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_EXCHANGE,
        OP_INCREMENT,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_BIT_MOVE,
        OP_TEST_CLEAR,
        OP_BIT_TEST
    } port_op_t;

endpackage

//--- verilog/dio_port.sv
/*
 * digital i/o port block: four 4-bit ports behind an apb slave.
 * assumes pin levels arrive asynchronously and are synchronised here;
 * the pad ring resolves pin_out / pin_oe_n / pullup_on into the wire.
 */
module dio_port
    import dio_port_pkg::*;
#(
    parameter logic [3:0] FIXED_PULLUP_P2 = 4'h0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins, four bits per port, port 0 in the low nibble
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    output logic [15:0] pullup_on
);
    import dio_port_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] dir_a_reg;
    logic [7:0] dir_c_reg;
    logic [7:0] pu_a_reg;
    logic [7:0] pu_b_reg;
    logic [15:0] latch_reg;
    logic [4:0] result_reg;
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic [7:0] dir_a_next;
    logic [7:0] dir_c_next;
    logic [7:0] pu_a_next;
    logic [7:0] pu_b_next;
    logic [15:0] out_mode;
    logic [15:0] view_all;
    logic setup_ph;
    logic acc_wr;
    logic op_wr;
    logic port_wr;
    logic [1:0] wr_port;
    logic [1:0] op_port;
    logic [1:0] op_bit;
    port_op_t op_code;
    logic addr_ok;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // direction bits per pin; the input-only port is never driven
    function automatic logic [15:0] mode_of(input logic [7:0] da, input logic [7:0] dc);
        mode_of = {{4{dc[DIR_C_PORT3_BIT]}}, 4'h0, da};
    endfunction

    // software pull-ups plus the fixed port 2 set, masked off wherever the pin is driven
    function automatic logic [15:0] pullup_of(input logic [15:0] md, input logic [7:0] pa,
                                              input logic [7:0] pb);
        logic [15:0] req;
        req = {{4{pb[PU_B_PORT3_BIT]}}, FIXED_PULLUP_P2,
               {4{pa[PU_A_PORT1_BIT]}}, {4{pa[PU_A_PORT0_BIT]}}};
        pullup_of = req & ~md;
    endfunction

    function automatic logic [3:0] nib(input logic [15:0] v, input logic [1:0] p);
        nib = v[4*p +: 4];
    endfunction

    // ----------------------------------------------------------------
    // synchroniser and read view
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign out_mode = mode_of(dir_a_reg, dir_c_reg);
    // driven pins show the latch, the rest show the pin level
    assign view_all = (out_mode & latch_reg) | (~out_mode & sync2_reg);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup_ph = psel && !penable;
    assign acc_wr = psel && penable && pready && pwrite;
    assign port_wr = acc_wr && paddr[11:4] == OFF_PORT_BASE[11:4] && paddr[1:0] == 2'h0;
    assign op_wr = acc_wr && paddr == OFF_OP;
    assign wr_port = paddr[3:2];
    assign op_port = pwdata[OP_PORT_LSB +: 2];
    assign op_bit = pwdata[OP_BIT_LSB +: 2];
    assign op_code = port_op_t'(pwdata[OP_CODE_LSB +: 3]);
    assign addr_ok = paddr == OFF_DIR_A || paddr == OFF_DIR_C || paddr == OFF_PU_A || paddr == OFF_PU_B
                     || paddr == OFF_OP || (paddr[11:4] == OFF_PORT_BASE[11:4] && paddr[1:0] == 2'h0);

    // one wait-free access phase: data and ready are prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            if (setup_ph && !pwrite) begin
                case (paddr)
                    OFF_DIR_A: prdata <= {24'h000000, dir_a_reg};
                    OFF_DIR_C: prdata <= {24'h000000, dir_c_reg};
                    OFF_PU_A: prdata <= {24'h000000, pu_a_reg};
                    OFF_PU_B: prdata <= {24'h000000, pu_b_reg};
                    OFF_OP: prdata <= {27'h0000000, result_reg};
                    default: begin
                        if (paddr[11:4] == OFF_PORT_BASE[11:4] && paddr[1:0] == 2'h0) begin
                            prdata <= {28'h0000000, nib(view_all, paddr[3:2])};
                        end else begin
                            prdata <= 32'h0000_0000;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_comb begin
        dir_a_next = dir_a_reg;
        dir_c_next = dir_c_reg;
        pu_a_next = pu_a_reg;
        pu_b_next = pu_b_reg;
        if (acc_wr && paddr == OFF_DIR_A) begin
            dir_a_next = pwdata[7:0];
        end
        if (acc_wr && paddr == OFF_DIR_C) begin
            dir_c_next = pwdata[7:0];
        end
        if (acc_wr && paddr == OFF_PU_A) begin
            pu_a_next = pwdata[7:0];
        end
        if (acc_wr && paddr == OFF_PU_B) begin
            pu_b_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_reg <= DIR_A_RESET;
            dir_c_reg <= DIR_C_RESET;
            pu_a_reg <= PU_A_RESET;
            pu_b_reg <= PU_B_RESET;
        end else begin
            dir_a_reg <= dir_a_next;
            dir_c_reg <= dir_c_next;
            pu_a_reg <= pu_a_next;
            pu_b_reg <= pu_b_next;
        end
    end

    // ----------------------------------------------------------------
    // pad controls
    // ----------------------------------------------------------------
    // built from the next values so a pull-up never overlaps a drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe_n <= 16'hFFFF;
            pullup_on <= {4'h0, FIXED_PULLUP_P2, 8'h00};
        end else begin
            pin_oe_n <= ~mode_of(dir_a_next, dir_c_next);
            pullup_on <= pullup_of(mode_of(dir_a_next, dir_c_next), pu_a_next, pu_b_next);
        end
    end

    // ----------------------------------------------------------------
    // output latches and single operations
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= {4{LATCH_RESET}};
            result_reg <= 5'h00;
        end else if (port_wr && wr_port != PORT_INPUT_ONLY) begin
            latch_reg[4*wr_port +: 4] <= pwdata[3:0];
        end else if (op_wr) begin
            case (op_code)
                OP_EXCHANGE: begin
                    result_reg[3:0] <= nib(view_all, op_port);
                    if (op_port != PORT_INPUT_ONLY) begin
                        latch_reg[4*op_port +: 4] <= pwdata[OP_DATA_LSB +: 4];
                    end
                end
                OP_INCREMENT: begin
                    result_reg[3:0] <= nib(view_all, op_port) + 4'h1;
                    if (op_port != PORT_INPUT_ONLY) begin
                        latch_reg[4*op_port +: 4] <= nib(view_all, op_port) + 4'h1;
                    end
                end
                OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_MOVE, OP_TEST_CLEAR: begin
                    // other bits of an input-mode port are left as they were, one legal
                    // outcome of their undefined state
                    result_reg[RESULT_BIT_POS] <= view_all[{op_port, op_bit}];
                    if (op_port != PORT_INPUT_ONLY) begin
                        latch_reg[{op_port, op_bit}] <= op_code == OP_BIT_SET
                            || (op_code == OP_BIT_MOVE && pwdata[OP_CARRY_BIT]);
                    end
                end
                OP_BIT_TEST: begin
                    result_reg[RESULT_BIT_POS] <= view_all[{op_port, op_bit}];
                end
                default: begin
                    result_reg <= result_reg;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {4{LATCH_RESET}};
        end else begin
            pin_out <= latch_reg;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_op(port_op_t c);
        op_wr && op_code == c && op_port != PORT_INPUT_ONLY;
    endsequence

    sequence s_port_write;
        port_wr && wr_port != PORT_INPUT_ONLY;
    endsequence

    a_pullup_never_driven: assert property (@(posedge pclk) disable iff (!presetn)
        (pullup_on & ~pin_oe_n) == 16'h0000)
        else $error("pull-up on while pin driven");

    a_oe_follows_dir: assert property (@(posedge pclk) disable iff (!presetn)
        pin_oe_n == ~out_mode)
        else $error("output enable disagrees with direction");

    a_write_to_pins: assert property (@(posedge pclk) disable iff (!presetn)
        s_port_write |-> ##2 nib(pin_out, $past(wr_port, 2)) == $past(pwdata[3:0], 2))
        else $error("port write did not reach pins");

    a_incr_latch: assert property (@(posedge pclk) disable iff (!presetn)
        s_op(OP_INCREMENT) |=> nib(latch_reg, $past(op_port)) == $past(nib(view_all, op_port)) + 4'h1)
        else $error("increment result wrong");

    a_exch_result: assert property (@(posedge pclk) disable iff (!presetn)
        s_op(OP_EXCHANGE) |=> result_reg[3:0] == $past(nib(view_all, op_port))
            && nib(latch_reg, $past(op_port)) == $past(pwdata[OP_DATA_LSB +: 4]))
        else $error("exchange result wrong");

    a_bit_only: assert property (@(posedge pclk) disable iff (!presetn)
        s_op(OP_BIT_SET) |=> latch_reg == ($past(latch_reg) | (16'h0001 << $past({op_port, op_bit}))))
        else $error("bit set touched other bits");

    a_read_view: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == OFF_PORT_BASE) |=> prdata[3:0] == $past(view_all[3:0]) && pready)
        else $error("port read returned wrong source");

    a_pu_group_a: assert property (@(posedge pclk) disable iff (!presetn)
        pullup_on[3:0] == ({4{pu_a_reg[PU_A_PORT0_BIT]}} & ~out_mode[3:0]))
        else $error("group a pull-up mismatch");

    a_pu_group_b: assert property (@(posedge pclk) disable iff (!presetn)
        pullup_on[15:12] == ({4{pu_b_reg[PU_B_PORT3_BIT]}} & ~out_mode[15:12]))
        else $error("group b pull-up mismatch");

endmodule

//--- test/core_model.sv
/*
 * core_model: apb master standing in for the processor core.
 * assumes pready is sampled at the rising edge of pclk.
 */
module core_model (
    // clock
    input wire logic pclk,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // apb answer
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // ----------------------------------------------------------------
    // one word per call
    // ----------------------------------------------------------------
    // request held until pready is seen; a dead slave is left to the bench watchdog
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines do not keep the last word
        pwdata <= ~d;
    endtask
endmodule

//--- test/test_digital_io_port_access.sv
/*
 * bench for dio_port: core_model drives apb, bench drives pin_in.
 * assumes the register map and op fields of dio_port_pkg.
 */
module test_digital_io_port_access import dio_port_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] FIX_P2 = 4'h5;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lf;
    logic [15:0] pin_in, pin_out, pin_oe_n, pullup_on;
    logic [3:0] lat [4];
    logic [7:0] dira, pua, pub;
    logic dirc;
    logic [64:0] q[$];
    int n_mismatch, cmp_count;
    core_model cm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready));
    dio_port #(.FIXED_PULLUP_P2(FIX_P2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_on(pullup_on));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // model and compare helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [15:0] outm();
        return {{4{dirc}}, 4'h0, dira};
    endfunction
    function automatic logic [3:0] view(input logic [1:0] p);
        logic [15:0] om;
        om = outm();
        return (lat[p] & om[p*4+:4]) | (pin_in[p*4+:4] & ~om[p*4+:4]);
    endfunction
    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_pins(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        logic [64:0] n;
        if (psel && penable && pready === 1'b1) begin
            n = (q.size() > 0) ? q.pop_front() : {1'b1, 64'h0};
            check_word("prdata", n[31:0] & n[63:32], prdata & n[63:32]);
            check_word("pslverr", {31'h0, n[64]}, {31'h0, pslverr});
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        q.push_back({1'b0, 64'h0});
        cm.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
        q.push_back({er, m, e});
        cm.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic chk_pins();
        logic [15:0] om, pu;
        repeat (3) @(posedge pclk);
        #1;
        om = outm();
        pu = {{4{pub[0]}}, FIX_P2, {4{pua[6]}}, {4{pua[3]}}} & ~om;
        check_pins("pin_oe_n", ~om, pin_oe_n);
        check_pins("pullup_on", pu, pullup_on);
        check_pins("pin_out", {lat[3], lat[2], lat[1], lat[0]} & om, pin_out & om);
    endtask
    task automatic cfg(input logic [7:0] a, input logic c, input logic [7:0] pa, input logic [7:0] pb);
        wr(OFF_DIR_A, {24'h0, a});
        wr(OFF_DIR_C, {31'h0, c});
        wr(OFF_PU_A, {24'h0, pa});
        wr(OFF_PU_B, {24'h0, pb});
        dira = a;
        dirc = c;
        pua = pa;
        pub = pb;
        chk_pins();
    endtask
    task automatic wport(input logic [1:0] p, input logic [3:0] d);
        wr(OFF_PORT_BASE + {8'h00, p, 2'b00}, {28'h0, d});
        if (p != 2'h2) lat[p] = d;
    endtask
    task automatic rports();
        for (int p = 0; p < 4; p++) rd(OFF_PORT_BASE + 12'(4 * p), {28'h0, view(2'(p))}, 32'hFFFF_FFFF, 1'b0);
    endtask
    task automatic op(input port_op_t c, input logic [1:0] p, input logic [1:0] b, input logic cy,
        input logic [3:0] d);
        logic [3:0] v, nl;
        logic [31:0] e, m;
        v = view(p);
        nl = lat[p];
        e = {27'h0, v[b], 4'h0};
        m = 32'h0000_0010;
        case (c)
            OP_EXCHANGE: begin
                e[3:0] = v;
                m = 32'h0000_000F;
                nl = d;
            end
            OP_INCREMENT: begin
                e[3:0] = v + 4'h1;
                m = 32'h0000_000F;
                nl = v + 4'h1;
            end
            OP_BIT_SET: nl[b] = 1'b1;
            OP_BIT_MOVE: nl[b] = cy;
            OP_BIT_CLEAR, OP_TEST_CLEAR: nl[b] = 1'b0;
            default: nl = lat[p];
        endcase
        wr(OFF_OP, {12'h0, d, 3'h0, cy, 2'h0, b, 2'h0, p, 1'b0, c});
        if (p != 2'h2) lat[p] = nl;
        rd(OFF_OP, e, m, 1'b0);
        chk_pins();
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        pin_in = 16'h0000;
        lf = 32'h22BF;
        for (int r = 0; r < 2; r++) begin
            {dira, dirc, pua, pub} = 25'h0;
            lat = '{4'h0, 4'h0, 4'h0, 4'h0};
            repeat (10) @(posedge pclk);
            presetn <= 1'b1;
            pin_in <= 16'(rnd());
            chk_pins();
            rd(OFF_DIR_A, 32'h0, 32'hFFFF_FFFF, 1'b0);
            rd(OFF_PU_B, 32'h0, 32'hFFFF_FFFF, 1'b0);
            rd(12'h030, 32'h0, 32'hFFFF_FFFF, 1'b1);
            rports();
            wport(2'h0, 4'(rnd()));
            wport(2'h3, 4'(rnd()));
            chk_pins();
            op(OP_EXCHANGE, 2'h1, 2'h0, 1'b0, 4'(rnd()));
            op(OP_INCREMENT, 2'h0, 2'h0, 1'b0, 4'h0);
            op(OP_BIT_SET, 2'h3, 2'h2, 1'b0, 4'h0);
            op(OP_BIT_TEST, 2'h1, 2'h3, 1'b0, 4'h0);
            cfg(8'h00, 1'b0, 8'h48, 8'h01);
            cfg(8'h00, 1'b0, 8'h08, 8'h00);
            cfg(8'hFF, 1'b1, 8'h48, 8'h01);
            pin_in <= ~pin_in;
            repeat (3) @(posedge pclk);
            rports();
            wport(2'h3, 4'(rnd()));
            wport(2'h1, 4'hF);
            op(OP_INCREMENT, 2'h1, 2'h0, 1'b0, 4'h0);
            op(OP_EXCHANGE, 2'h0, 2'h0, 1'b0, 4'(rnd()));
            for (int c = 3; c < 8; c++) op(port_op_t'(c), 2'(c), 2'(c + r), lf[0], 4'h0);
            cfg(8'h5A, 1'b0, 8'h48, 8'h01);
            rports();
            op(OP_INCREMENT, 2'h1, 2'h0, 1'b0, 4'h0);
            wport(2'h2, 4'hA);
            op(OP_EXCHANGE, 2'h2, 2'h1, 1'b0, 4'h3);
            presetn <= 1'b0;
        end
        test_done();
    end
endmodule
